// *** hw/mcs_pkg.sv ***
/*
  Shared constants and carrier types for the MAC client statistics and
  receive stream block. Assumes a single clock domain and an APB master.
*/
package mcs_pkg;

  // Transmit statistics word bit positions.
  localparam int unsigned B_PAUSE  = 31;
  localparam int unsigned B_BYTE   = 30;
  localparam int unsigned B_RSV_HI = 29;
  localparam int unsigned B_ATT_LO = 25;
  localparam int unsigned B_RSV_LO = 24;
  localparam int unsigned B_XCOL   = 23;
  localparam int unsigned B_LCOL   = 22;
  localparam int unsigned B_XDEF   = 21;
  localparam int unsigned B_DEF    = 20;
  localparam int unsigned B_VLAN   = 19;
  localparam int unsigned B_LEN_LO = 5;
  localparam int unsigned B_CTRL   = 4;
  localparam int unsigned B_UNDR   = 3;
  localparam int unsigned B_MC     = 2;
  localparam int unsigned B_BC     = 1;
  localparam int unsigned B_OK     = 0;

  // Frame field positions and values.
  localparam logic [13:0] LEN_SAT  = 14'h3FF0;
  localparam logic [13:0] IDX_DA0  = 14'h0000;
  localparam logic [13:0] IDX_DA5  = 14'h0005;
  localparam logic [13:0] IDX_TYH  = 14'h000C;
  localparam logic [13:0] IDX_TYL  = 14'h000D;
  localparam logic [15:0] TYPE_CTL = 16'h8808;
  localparam logic [15:0] TYPE_VLN = 16'h8100;
  localparam logic [7:0]  BYTE_BC  = 8'hFF;
  localparam logic [3:0]  ATT_MAX  = 4'hF;
  localparam logic [4:0]  COL_LIM  = 5'h0F;
  localparam logic [4:0]  COL_SAT  = 5'h10;

  // Register offsets and reset values.
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_FILT  = 8'h04;
  localparam logic [7:0]  OFS_TXST  = 8'h08;
  localparam logic [7:0]  OFS_RXST  = 8'h0C;
  localparam logic [7:0]  OFS_TXCNT = 8'h10;
  localparam logic [7:0]  OFS_RXCNT = 8'h14;
  localparam logic [1:0]  CTRL_RST  = 2'h3;
  localparam int unsigned CTRL_VLAN = 0;
  localparam int unsigned CTRL_AV   = 1;

  // Per-cycle events from the transmit engine.
  typedef struct packed {
    logic       pause_gen;
    logic       byte_act;
    logic [7:0] tx_byte;
    logic       attempt;
    logic       collision;
    logic       late_col;
    logic       deferred;
    logic       defer_limit_hit;
    logic       underrun;
    logic       frame_end;
  } mcs_tx_ev_t;

  // Received bytes from the receive engine.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       err;
    logic       av;
  } mcs_rx_in_t;

  // One byte-wide stream beat.
  typedef struct packed {
    logic [7:0] tdata;
    logic       tvalid;
    logic       tlast;
    logic       tuser;
  } mcs_axis_t;

endpackage

// *** hw/mcs_client_stats.sv ***
/*
  Client-side transmit statistics, receive streams and receive statistics
  of an Ethernet MAC, with an APB register window.
  Assumes the transmit and receive engines drive their inputs from pclk.
*/
`timescale 1ns/1ps
module mcs_client_stats #(
  parameter int unsigned NFILT = 4,
  parameter bit          AV_EN = 1'b1
) (
  // Clock and reset.
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // APB slave.
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Transmit engine events and statistics.
  input  wire mcs_pkg::mcs_tx_ev_t    tx_ev,
  output logic      [31:0]            tx_stats_vec,
  output logic                        tx_stats_valid,
  // Receive engine inputs.
  input  wire mcs_pkg::mcs_rx_in_t    rx_in,
  input  wire logic [NFILT-1:0]       rx_filt_match,
  input  wire logic [27:0]            rx_stats_in,
  input  wire logic                   rx_stats_done,
  // Main receive stream.
  output mcs_pkg::mcs_axis_t          rx_axis,
  output logic      [NFILT-1:0]       rx_filt_tuser,
  // AV receive stream.
  output logic      [7:0]             av_recv_byte_out,
  output logic                        av_recv_valid,
  output logic                        av_recv_last,
  output logic                        av_recv_err,
  // Receive statistics.
  output logic      [27:0]            rx_stats_vec,
  output logic                        rx_stats_valid
);

  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == mcs_pkg::OFS_CTRL) || (a == mcs_pkg::OFS_FILT) ||
              (a == mcs_pkg::OFS_TXST) || (a == mcs_pkg::OFS_RXST) ||
              (a == mcs_pkg::OFS_TXCNT) || (a == mcs_pkg::OFS_RXCNT);
  endfunction

  logic [1:0]       ctrl_ff;
  logic [NFILT-1:0] filt_en_ff;
  logic [31:0]      tx_cnt_ff;
  logic [31:0]      rx_cnt_ff;
  logic [31:0]      prdata_ff;
  logic [31:0]      rdata;
  logic             wr_en;

  // Transmit frame accumulators.
  logic [13:0]      len_ff;
  logic             in_frame_ff;
  logic [3:0]       att_ff;
  logic             col_now_ff;
  logic [4:0]       streak_ff;
  logic             lcol_ff;
  logic             def_ff;
  logic             xdef_ff;
  logic             undr_ff;
  logic             pause_ff;
  logic             mc_ff;
  logic             bc_ff;
  logic [7:0]       type_hi_ff;
  logic             ctl_ff;
  logic             vlan_ff;
  logic [31:0]      tx_stats_ff;
  logic             tx_valid_ff;
  logic [31:0]      nxt_tx_stats;
  logic             col_any;
  logic             xcol;
  logic             lcol;
  logic             xdef;
  logic             undr;

  // Receive side registers.
  mcs_pkg::mcs_axis_t rx_axis_ff;
  logic [NFILT-1:0] filt_tag_ff;
  logic [7:0]       av_data_ff;
  logic             av_valid_ff;
  logic             av_last_ff;
  logic             av_err_ff;
  logic [27:0]      rx_stats_ff;
  logic             rx_stats_vld_ff;
  logic             to_av;

  // APB: zero wait states, error on unmapped offsets.
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);
  assign wr_en   = psel && penable && pwrite && reg_hit(paddr);
  assign prdata  = prdata_ff;

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (paddr)
      mcs_pkg::OFS_CTRL:  rdata = {30'h0000_0000, ctrl_ff};
      mcs_pkg::OFS_FILT:  rdata = 32'(filt_en_ff);
      mcs_pkg::OFS_TXST:  rdata = tx_stats_ff;
      mcs_pkg::OFS_RXST:  rdata = {4'h0, rx_stats_ff};
      mcs_pkg::OFS_TXCNT: rdata = tx_cnt_ff;
      mcs_pkg::OFS_RXCNT: rdata = rx_cnt_ff;
      default:            rdata = 32'h0000_0000;
    endcase
  end

  // Read data is latched in the setup cycle so it is stable for the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff    <= mcs_pkg::CTRL_RST;
      filt_en_ff <= '0;
    end else if (wr_en) begin
      if (paddr == mcs_pkg::OFS_CTRL) begin
        ctrl_ff <= pwdata[1:0];
      end
      if (paddr == mcs_pkg::OFS_FILT) begin
        filt_en_ff <= pwdata[NFILT-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_cnt_ff <= 32'h0000_0000;
      rx_cnt_ff <= 32'h0000_0000;
    end else begin
      if (tx_ev.frame_end) begin
        tx_cnt_ff <= tx_cnt_ff + 32'h0000_0001;
      end
      if (rx_stats_done) begin
        rx_cnt_ff <= rx_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // Each new attempt restarts the byte-level decode of the frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      len_ff     <= 14'h0000;
      mc_ff      <= 1'b0;
      bc_ff      <= 1'b0;
      type_hi_ff <= 8'h00;
      ctl_ff     <= 1'b0;
      vlan_ff    <= 1'b0;
    end else if (tx_ev.attempt || tx_ev.frame_end) begin
      len_ff     <= 14'h0000;
      mc_ff      <= 1'b0;
      bc_ff      <= 1'b0;
      type_hi_ff <= 8'h00;
      ctl_ff     <= 1'b0;
      vlan_ff    <= 1'b0;
    end else if (tx_ev.byte_act) begin
      if (len_ff != mcs_pkg::LEN_SAT) begin
        len_ff <= len_ff + 14'h0001;
      end
      if (len_ff == mcs_pkg::IDX_DA0) begin
        mc_ff <= tx_ev.tx_byte[0];
        bc_ff <= (tx_ev.tx_byte == mcs_pkg::BYTE_BC);
      end else if (len_ff <= mcs_pkg::IDX_DA5) begin
        bc_ff <= bc_ff && (tx_ev.tx_byte == mcs_pkg::BYTE_BC);
      end
      if (len_ff == mcs_pkg::IDX_TYH) begin
        type_hi_ff <= tx_ev.tx_byte;
      end
      if (len_ff == mcs_pkg::IDX_TYL) begin
        ctl_ff  <= ({type_hi_ff, tx_ev.tx_byte} == mcs_pkg::TYPE_CTL);
        vlan_ff <= ({type_hi_ff, tx_ev.tx_byte} == mcs_pkg::TYPE_VLN);
      end
    end
  end

  // Attempt count and collision streak across retries of one frame.
  // The streak only counts attempts already finished; the attempt in flight
  // joins it at frame end through col_any, which saves a second counter.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_frame_ff <= 1'b0;
      att_ff      <= 4'h0;
      col_now_ff  <= 1'b0;
      streak_ff   <= 5'h00;
    end else if (tx_ev.frame_end) begin
      in_frame_ff <= 1'b0;
      att_ff      <= 4'h0;
      col_now_ff  <= 1'b0;
      streak_ff   <= 5'h00;
    end else begin
      if (tx_ev.attempt) begin
        in_frame_ff <= 1'b1;
        col_now_ff  <= tx_ev.collision;
        if (in_frame_ff) begin
          if (att_ff != mcs_pkg::ATT_MAX) begin
            att_ff <= att_ff + 4'h1;
          end
          if (col_now_ff && streak_ff != mcs_pkg::COL_SAT) begin
            streak_ff <= streak_ff + 5'h01;
          end else if (!col_now_ff) begin
            streak_ff <= 5'h00;
          end
        end
      end else if (tx_ev.collision) begin
        col_now_ff <= 1'b1;
      end
    end
  end

  // Sticky per-frame flags; an event in the closing cycle still counts.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcol_ff  <= 1'b0;
      def_ff   <= 1'b0;
      xdef_ff  <= 1'b0;
      undr_ff  <= 1'b0;
      pause_ff <= 1'b0;
    end else if (tx_ev.frame_end) begin
      lcol_ff  <= 1'b0;
      def_ff   <= 1'b0;
      xdef_ff  <= 1'b0;
      undr_ff  <= 1'b0;
      pause_ff <= 1'b0;
    end else begin
      lcol_ff  <= lcol_ff || tx_ev.late_col;
      def_ff   <= def_ff || tx_ev.deferred;
      xdef_ff  <= xdef_ff || tx_ev.defer_limit_hit;
      undr_ff  <= undr_ff || tx_ev.underrun;
      pause_ff <= pause_ff || tx_ev.pause_gen;
    end
  end

  assign col_any = col_now_ff || tx_ev.collision;
  assign xcol    = col_any && (streak_ff >= mcs_pkg::COL_LIM);
  assign lcol    = lcol_ff || tx_ev.late_col;
  assign xdef    = xdef_ff || tx_ev.defer_limit_hit;
  assign undr    = undr_ff || tx_ev.underrun;

  // Bit 30 refreshes every cycle while the other fields wait for frame end,
  // so a client must sample the word only on the valid pulse.
  always_comb begin
    nxt_tx_stats = tx_stats_ff;
    nxt_tx_stats[mcs_pkg::B_BYTE] = tx_ev.byte_act;
    if (tx_ev.frame_end) begin
      nxt_tx_stats[mcs_pkg::B_PAUSE] = pause_ff || tx_ev.pause_gen;
      nxt_tx_stats[mcs_pkg::B_ATT_LO +: 4] = att_ff;
      nxt_tx_stats[mcs_pkg::B_XCOL] = xcol;
      nxt_tx_stats[mcs_pkg::B_LCOL] = lcol;
      nxt_tx_stats[mcs_pkg::B_XDEF] = xdef;
      nxt_tx_stats[mcs_pkg::B_DEF] = def_ff || tx_ev.deferred;
      nxt_tx_stats[mcs_pkg::B_VLAN] = vlan_ff && ctrl_ff[mcs_pkg::CTRL_VLAN];
      nxt_tx_stats[mcs_pkg::B_LEN_LO +: 14] = len_ff;
      nxt_tx_stats[mcs_pkg::B_CTRL] = ctl_ff;
      nxt_tx_stats[mcs_pkg::B_UNDR] = undr;
      nxt_tx_stats[mcs_pkg::B_MC] = mc_ff && !bc_ff;
      nxt_tx_stats[mcs_pkg::B_BC] = bc_ff;
      nxt_tx_stats[mcs_pkg::B_OK] = !(xcol || lcol || xdef || undr);
    end
    nxt_tx_stats[mcs_pkg::B_RSV_HI] = 1'b0;
    nxt_tx_stats[mcs_pkg::B_RSV_LO] = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_stats_ff <= 32'h0000_0000;
      tx_valid_ff <= 1'b0;
    end else begin
      tx_stats_ff <= nxt_tx_stats;
      tx_valid_ff <= tx_ev.frame_end;
    end
  end

  assign tx_stats_vec   = tx_stats_ff;
  assign tx_stats_valid = tx_valid_ff;

  // AV frames leave on the second stream only when built in and enabled.
  assign to_av = AV_EN && ctrl_ff[mcs_pkg::CTRL_AV] && rx_in.av;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_axis_ff <= '0;
    end else begin
      rx_axis_ff.tdata  <= rx_in.data;
      rx_axis_ff.tvalid <= rx_in.valid && !to_av;
      rx_axis_ff.tlast  <= rx_in.valid && !to_av && rx_in.last;
      rx_axis_ff.tuser  <= rx_in.valid && !to_av && rx_in.last && rx_in.err;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      av_data_ff  <= 8'h00;
      av_valid_ff <= 1'b0;
      av_last_ff  <= 1'b0;
      av_err_ff   <= 1'b0;
    end else begin
      av_data_ff  <= rx_in.data;
      av_valid_ff <= rx_in.valid && to_av;
      av_last_ff  <= rx_in.valid && to_av && rx_in.last;
      av_err_ff   <= rx_in.valid && to_av && rx_in.last && rx_in.err;
    end
  end

  // A tag marks frames that an enabled filter rejected, so the client can drop them.
  for (genvar i = 0; i < NFILT; i++) begin : g_filt
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        filt_tag_ff[i] <= 1'b0;
      end else begin
        filt_tag_ff[i] <= rx_in.valid && rx_in.last && filt_en_ff[i] &&
                          !rx_filt_match[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_stats_ff     <= 28'h000_0000;
      rx_stats_vld_ff <= 1'b0;
    end else begin
      rx_stats_vld_ff <= rx_stats_done;
      if (rx_stats_done) begin
        rx_stats_ff <= rx_stats_in;
      end
    end
  end

  // All receive outputs are high-true and come straight from flip-flops.
  assign rx_axis          = rx_axis_ff;
  assign rx_filt_tuser    = filt_tag_ff;
  assign av_recv_byte_out = av_data_ff;
  assign av_recv_valid    = av_valid_ff;
  assign av_recv_last     = av_last_ff;
  assign av_recv_err      = av_err_ff;
  assign rx_stats_vec     = rx_stats_ff;
  assign rx_stats_valid   = rx_stats_vld_ff;

endmodule

// *** sim/mcs_client_stats_props.sv ***
/*
  Checker for mcs_client_stats: transmit statistics and receive stream timing.
  Assumes one clock, pclk, and reset presetn, bound to the design top.
*/
`timescale 1ns/1ps
module mcs_client_stats_props #(
  parameter int unsigned NFILT = 4
) (
  // Clock and reset.
  input wire logic                pclk,
  input wire logic                presetn,
  // Transmit side.
  input wire mcs_pkg::mcs_tx_ev_t tx_ev,
  input wire logic [31:0]         tx_stats_vec,
  input wire logic                tx_stats_valid,
  // Receive side.
  input wire mcs_pkg::mcs_rx_in_t rx_in,
  input wire logic [27:0]         rx_stats_in,
  input wire logic                rx_stats_done,
  input wire mcs_pkg::mcs_axis_t  rx_axis,
  input wire logic                av_recv_valid,
  input wire logic                av_recv_last,
  input wire logic                av_recv_err,
  input wire logic [27:0]         rx_stats_vec,
  input wire logic                rx_stats_valid
);
  logic [13:0] len_ff;
  logic [4:0]  att_ff;
  logic [3:0]  nxt_att;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // A retry restarts the count, so only the final attempt's bytes are seen.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) len_ff <= 14'h0000;
    else if (tx_ev.attempt) len_ff <= 14'h0000;
    else if (tx_ev.byte_act && len_ff != 14'h3FF0) len_ff <= len_ff + 14'h0001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) att_ff <= 5'h00;
    else if (tx_ev.frame_end) att_ff <= 5'h00;
    else if (tx_ev.attempt && att_ff != 5'h10) att_ff <= att_ff + 5'h01;
  end
  assign nxt_att = (att_ff == 5'h00) ? 4'h0 : 4'(att_ff - 5'h01);

  a_valid_pulse: assert property (tx_ev.frame_end |=> tx_stats_valid)
    else $error("tx stats valid missing after frame end");
  a_byte_on: assert property (tx_ev.byte_act |=> tx_stats_vec[30])
    else $error("byte flag not following byte activity");
  a_byte_off: assert property (!tx_ev.byte_act |=> !tx_stats_vec[30])
    else $error("byte flag high without byte activity");
  a_rsvd_zero: assert property (!tx_stats_vec[29] && !tx_stats_vec[24])
    else $error("reserved stats bit set");
  a_ok_clean: assert property (tx_stats_valid |-> tx_stats_vec[0] ==
    !(tx_stats_vec[23] | tx_stats_vec[22] | tx_stats_vec[21] | tx_stats_vec[3]))
    else $error("success bit disagrees with error bits");
  a_len_count: assert property (tx_ev.frame_end |=> tx_stats_vec[18:5] == $past(len_ff))
    else $error("frame length wrong");
  a_att_count: assert property (tx_ev.frame_end |=> tx_stats_vec[28:25] == $past(nxt_att))
    else $error("attempt count wrong");
  a_rx_beat: assert property (rx_in.valid |=> rx_axis.tvalid || av_recv_valid)
    else $error("receive beat lost");
  a_rx_data: assert property (rx_axis.tvalid |-> rx_axis.tdata == $past(rx_in.data) &&
    rx_axis.tlast == $past(rx_in.last))
    else $error("receive data or last wrong");
  a_rx_user: assert property (rx_axis.tuser |-> rx_axis.tvalid && rx_axis.tlast)
    else $error("error flag away from last byte");
  a_av_err: assert property (av_recv_err |-> av_recv_valid && av_recv_last)
    else $error("av error flag away from last byte");
  a_rxst_upd: assert property (rx_stats_done |=>
    rx_stats_valid && rx_stats_vec == $past(rx_stats_in))
    else $error("receive stats not presented");

  c_xcol: cover property (tx_stats_valid && tx_stats_vec[23]);
  c_rx_err: cover property (rx_axis.tuser);
  c_av_last: cover property (av_recv_valid && av_recv_last);
endmodule

bind mcs_client_stats mcs_client_stats_props #(.NFILT(NFILT)) u_props (
  .pclk, .presetn, .tx_ev, .tx_stats_vec, .tx_stats_valid, .rx_in, .rx_stats_in,
  .rx_stats_done, .rx_axis, .av_recv_valid, .av_recv_last, .av_recv_err,
  .rx_stats_vec, .rx_stats_valid
);

// *** sim/mcs_client_model.sv ***
/*
  Client logic model: counts frames and statistics words that it accepts.
  Assumes the design outputs are active high and synchronous to pclk.
*/
`timescale 1ns/1ps
module mcs_client_model (
  // Clock and reset.
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Watched outputs.
  input  wire mcs_pkg::mcs_axis_t rx_axis,
  input  wire logic               av_recv_valid,
  input  wire logic               av_recv_last,
  input  wire logic               tx_stats_valid,
  // Counts.
  output logic [15:0]             n_tx,
  output logic [15:0]             n_rx,
  output logic [15:0]             n_av
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_tx <= 16'h0000;
      n_rx <= 16'h0000;
      n_av <= 16'h0000;
    end else begin
      n_tx <= n_tx + 16'(tx_stats_valid);
      n_rx <= n_rx + 16'(rx_axis.tvalid & rx_axis.tlast);
      n_av <= n_av + 16'(av_recv_valid & av_recv_last);
    end
  end
endmodule

// *** sim/testbench.sv ***
/*
  Self-checking bench for mcs_client_stats with the client model beside it.
  Assumes one pclk domain; engines and APB are driven here.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
  logic                pclk = 1'h0;
  logic                presetn = 1'h0;
  logic [7:0]          paddr = 8'h00;
  logic                psel = 1'h0;
  logic                penable = 1'h0;
  logic                pwrite = 1'h0;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  mcs_pkg::mcs_tx_ev_t tx_ev = 17'h0;
  logic [31:0]         tx_stats_vec;
  logic                tx_stats_valid;
  mcs_pkg::mcs_rx_in_t rx_in = 12'h0;
  logic [3:0]          rx_filt_match = 4'h0;
  logic [27:0]         rx_stats_in = 28'h0;
  logic                rx_stats_done = 1'h0;
  mcs_pkg::mcs_axis_t  rx_axis;
  logic [3:0]          rx_filt_tuser;
  logic [7:0]          av_recv_byte_out;
  logic                av_recv_valid;
  logic                av_recv_last;
  logic                av_recv_err;
  logic [27:0]         rx_stats_vec;
  logic                rx_stats_valid;
  logic [15:0]         n_tx;
  logic [15:0]         n_rx;
  logic [15:0]         n_av;
  logic [31:0]         q_tx[$];
  logic [27:0]         q_rs[$];
  logic [14:0]         q_rx[$];
  logic [31:0]         lastw = 32'h0;
  logic [27:0]         lasts = 28'h0;
  logic [31:0]         exp_tx;
  logic [27:0]         exp_rs;
  logic [14:0]         exp_rx;
  logic [14:0]         got_rx;
  logic [3:0]          filt_en = 4'h0;
  logic                vlan_en = 1'h1;
  logic                av_en = 1'h1;
  int                  n_mismatch = 0;
  int                  cmp_count = 0;
  int                  ntx = 0;
  int                  nrx = 0;
  int                  nav = 0;
  int                  cyc = 0;

  mcs_client_stats dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .tx_ev, .tx_stats_vec, .tx_stats_valid, .rx_in, .rx_filt_match,
    .rx_stats_in, .rx_stats_done, .rx_axis, .rx_filt_tuser, .av_recv_byte_out,
    .av_recv_valid, .av_recv_last, .av_recv_err, .rx_stats_vec, .rx_stats_valid
  );
  mcs_client_model cl (
    .pclk, .presetn, .rx_axis, .av_recv_valid, .av_recv_last, .tx_stats_valid,
    .n_tx, .n_rx, .n_av
  );

  always #50 pclk = ~pclk;

  task automatic finish_test;
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      finish_test;
    end
  end

  // Outputs are registered, so the falling edge sees them settled.
  always @(negedge pclk) begin
    if (tx_stats_valid === 1'h1) begin
      exp_tx = (q_tx.size() > 0) ? q_tx.pop_front() : ~tx_stats_vec;
      `CHK(tx_stats_vec, exp_tx)
    end
    if (rx_stats_valid === 1'h1) begin
      exp_rs = (q_rs.size() > 0) ? q_rs.pop_front() : ~rx_stats_vec;
      `CHK(rx_stats_vec, exp_rs)
    end
    if (rx_axis.tvalid === 1'h1) begin
      got_rx = {1'h0, rx_axis.tdata, rx_axis.tlast, rx_axis.tuser, rx_filt_tuser};
      exp_rx = (q_rx.size() > 0) ? q_rx.pop_front() : ~got_rx;
      `CHK(got_rx, exp_rx)
    end
    if (av_recv_valid === 1'h1) begin
      got_rx = {1'h1, av_recv_byte_out, av_recv_last, av_recv_err, 4'h0};
      exp_rx = (q_rx.size() > 0) ? q_rx.pop_front() : ~got_rx;
      `CHK(got_rx, exp_rx)
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] ex, input logic er);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    if (!w) `CHK(prdata, ex)
    `CHK(pslverr, er)
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic tx_frame(input int n, input int att, input logic [7:0] b0,
                          input logic [15:0] ty, input logic col, input logic [4:0] fl);
    logic [7:0]  b;
    logic        bc;
    logic        xc;
    logic [13:0] len;
    for (int i = 0; i < att; i++) begin
      @(posedge pclk);
      tx_ev <= 17'h00040;
      @(posedge pclk);
      tx_ev <= {11'h000, col, 5'h00};
    end
    for (int i = 0; i < n; i++) begin
      b = (i < 6) ? b0 : (i == 12) ? ty[15:8] : (i == 13) ? ty[7:0] : 8'($urandom);
      @(posedge pclk);
      tx_ev <= {fl[4], 1'h1, b, 2'h0, fl[3:0], 1'h0};
    end
    bc = (b0 == 8'hFF);
    xc = col && att >= 16;
    len = (n > 16368) ? 14'h3FF0 : 14'(n);
    lastw = {fl[4], 2'h0, (att > 16) ? 4'hF : 4'(att - 1), 1'h0, xc, fl[3], fl[1], fl[2],
             ty == 16'h8100 && vlan_en, len, ty == 16'h8808, fl[0], b0[0] & !bc, bc,
             !(xc | fl[3] | fl[1] | fl[0])};
    q_tx.push_back(lastw);
    ntx++;
    @(posedge pclk);
    tx_ev <= 17'h00001;
    @(posedge pclk);
    tx_ev <= 17'h0;
  endtask

  task automatic rx_frame(input int n, input logic er, input logic av, input logic [3:0] m);
    logic [7:0] d;
    logic       l;
    logic       r;
    r = av & av_en;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      l = (i == n - 1);
      @(posedge pclk);
      rx_in <= {1'h1, d, l, er & l, av};
      rx_filt_match <= m;
      q_rx.push_back({r, d, l, er & l, (l && !r) ? filt_en & ~m : 4'h0});
    end
    if (r) nav++;
    else nrx++;
    lasts = 28'($urandom);
    @(posedge pclk);
    rx_in <= 12'h0;
    rx_stats_in <= lasts;
    rx_stats_done <= 1'h1;
    q_rs.push_back(lasts);
    @(posedge pclk);
    rx_stats_done <= 1'h0;
  endtask

  initial begin
    cyc = $urandom(7985);
    cyc = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h00, 32'h0, 32'h3, 1'h0);
    apb(1'h0, 8'h04, 32'h0, 32'h0, 1'h0);
    filt_en = 4'h5;
    apb(1'h1, 8'h04, 32'h5, 32'h0, 1'h0);
    apb(1'h0, 8'h04, 32'h0, 32'h5, 1'h0);
    apb(1'h1, 8'h08, 32'hFFFFFFFF, 32'h0, 1'h0);
    apb(1'h0, 8'h08, 32'h0, 32'h0, 1'h0);
    apb(1'h1, 8'h40, 32'h1, 32'h0, 1'h1);
    apb(1'h0, 8'h40, 32'h0, 32'h0, 1'h1);
    tx_frame(20, 1, 8'hFF, 16'h0800, 1'h0, 5'h00);
    tx_frame(64, 1, 8'h01, 16'h8808, 1'h0, 5'h00);
    tx_frame(60, 3, 8'h02, 16'h8100, 1'h1, 5'h04);
    tx_frame(30, 16, 8'h00, 16'h0000, 1'h1, 5'h00);
    tx_frame(40, 1, 8'h00, 16'h0000, 1'h0, 5'h1B);
    tx_frame(16400, 1, 8'h00, 16'h0000, 1'h0, 5'h00);
    apb(1'h0, 8'h08, 32'h0, lastw, 1'h0);
    apb(1'h0, 8'h10, 32'h0, 32'(ntx), 1'h0);
    rx_frame(5, 1'h0, 1'h0, 4'h1);
    rx_frame(3, 1'h1, 1'h0, 4'h0);
    rx_frame(4, 1'h1, 1'h1, 4'h0);
    vlan_en = 1'h0;
    av_en = 1'h0;
    apb(1'h1, 8'h00, 32'h0, 32'h0, 1'h0);
    rx_frame(2, 1'h0, 1'h1, 4'hF);
    tx_frame(20, 1, 8'h00, 16'h8100, 1'h0, 5'h00);
    apb(1'h0, 8'h0C, 32'h0, 32'(lasts), 1'h0);
    apb(1'h0, 8'h14, 32'h0, 32'h4, 1'h0);
    for (int k = 0; k < 20; k++) begin
      tx_frame(14 + $urandom % 50, 1 + $urandom % 4, 8'($urandom), 16'($urandom),
               1'($urandom), 5'($urandom));
      rx_frame(1 + $urandom % 9, 1'($urandom), 1'($urandom), 4'($urandom));
    end
    repeat (5) @(posedge pclk);
    `CHK(n_tx, 16'(ntx))
    `CHK(n_rx, 16'(nrx))
    `CHK(n_av, 16'(nav))
    finish_test;
  end
endmodule
